// *** src/cdm_core_exec.sv ***
// execution of branch, data move, bit and control operations
// assumes decoded operations on the issue port, a synchronous code memory and a data memory whose read data is valid while dmemRe is high
`timescale 1ns/1ns
`default_nettype none
module cdm_core_exec import cdm_pkg::*; (
  input wire logic mclk, // core clock
  input wire logic reset_n, // async reset
  input wire logic issue, // operation offered
  input wire cdm_op_e op, // operation
  input wire logic [4:0] rdSel, // destination register
  input wire logic [4:0] rrSel, // source register
  input wire logic [2:0] bitSel, // bit or flag index
  input wire logic [1:0] ptrSel, // pointer pair
  input wire cdm_pm_e ptrMode, // pointer mode
  input wire cdm_sh_e shKind, // shift kind
  input wire logic [7:0] imm, // immediate byte
  input wire logic [5:0] disp, // displacement
  input wire logic [15:0] dirAddr, // direct address
  input wire logic [6:0] brOfs, // signed branch offset
  input wire logic [5:0] opIo, // io address of the op
  input wire logic [4:0] dbgSel, // register to observe
  input wire logic [7:0] dmemRdata, // data memory read
  input wire logic [7:0] pmemRdata, // code memory read
  input wire logic [7:0] ioRdata, // io value at opIo
  output logic ready, // can take an op
  output logic done, // op retired
  output logic [15:0] pc, // program counter
  output logic [7:0] status_flag_register, // status flags
  output logic [15:0] sp, // stack pointer
  output logic [7:0] dbgData, // observed register
  output logic [15:0] dmemAddr, // data address
  output logic [7:0] dmemWdata, // data write byte
  output logic dmemWe, // data write strobe
  output logic dmemRe, // data read strobe
  output logic [15:0] pmemAddr, // code byte address
  output logic pmemRe, // code read strobe
  output logic [5:0] ioAddr, // io address
  output logic [7:0] ioWdata, // io write byte
  output logic ioWe, // io write strobe
  output logic sleepReq, // sleep hand-off
  output logic wdtKick, // watchdog restart
  output logic breakReq // debug break
);
  typedef enum {ST_IDLE, ST_WAIT} cdm_st_e;
  cdm_st_e state;
  logic [1:0] cnt;
  cdm_op_e opR;
  logic [4:0] rdR;
  logic [7:0] rf [32];
  logic take, finish, brTaken;
  logic [1:0] nCyc, effPtr;
  logic [4:0] ptrLo, ptrHi;
  logic [15:0] ptrVal, ptrInc, ptrDec, ofsAddr, indAddr, brTgt;
  logic [7:0] rdVal, rrVal, shRes;
  logic shC, shZ, shN, shV, shS;

  // ==========================================================
  // decode
  assign take = issue && ready;
  assign finish = (state == ST_WAIT) && (cnt == CYC_ONE);
  assign rdVal = rf[rdSel];
  assign rrVal = rf[rrSel];
  // X has no displacement form; offset ops fall back to Y
  always_comb begin
    effPtr = ptrSel;
    if (op == OP_CODE_RD) begin
      effPtr = PTR_Z;
    end else if ((op == OP_RD_OFS || op == OP_WR_OFS) && ptrSel == PTR_X) begin
      effPtr = PTR_Y;
    end
  end
  assign ptrLo = (effPtr == PTR_X) ? X_LO : (effPtr == PTR_Y) ? Y_LO : Z_LO;
  assign ptrHi = ptrLo | 5'h01;
  assign ptrVal = {rf[ptrHi], rf[ptrLo]};
  assign ptrInc = ptrVal + 16'h0001;
  assign ptrDec = ptrVal - 16'h0001;
  assign ofsAddr = ptrVal + {10'h000, disp};
  assign indAddr = (ptrMode == PM_PREDEC) ? ptrDec : ptrVal;
  assign brTgt = pc + {{9{brOfs[6]}}, brOfs} + 16'h0001;
  always_comb begin
    case (op)
      OP_BR_IRQ_ON: brTaken = status_flag_register[FLG_I];
      OP_BR_IRQ_OFF: brTaken = !status_flag_register[FLG_I];
      OP_BR_NO_OVF: brTaken = !status_flag_register[FLG_V];
      default: brTaken = 1'b0;
    endcase
  end
  always_comb begin
    case (op)
      OP_BR_IRQ_ON, OP_BR_IRQ_OFF, OP_BR_NO_OVF:
        nCyc = brTaken ? CYC_TWO : CYC_ONE;
      OP_RD_IND, OP_RD_OFS, OP_RD_DIR, OP_WR_IND, OP_WR_OFS, OP_WR_DIR,
      OP_PUSH, OP_POP, OP_IO_SET, OP_IO_CLR: nCyc = CYC_TWO;
      OP_CODE_RD: nCyc = CYC_THREE;
      default: nCyc = CYC_ONE;
    endcase
  end
  cdm_shift_unit #(.W(8)) u_shift (
    .kind(shKind),
    .a(rdVal),
    .cin(status_flag_register[FLG_C]),
    .res(shRes),
    .cOut(shC),
    .zOut(shZ),
    .nOut(shN),
    .vOut(shV),
    .sOut(shS)
  );

  // ==========================================================
  // sequencing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      cnt <= 2'h0;
      ready <= 1'b1;
      done <= 1'b0;
      opR <= OP_IDLE;
      rdR <= 5'h00;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            opR <= op;
            rdR <= (op == OP_CODE_RD && ptrMode == PM_PLAIN) ? rdSel : rdSel;
            if (nCyc == CYC_ONE) begin
              done <= 1'b1;
            end else begin
              state <= ST_WAIT;
              cnt <= nCyc - CYC_ONE;
              ready <= 1'b0;
            end
          end
        end
        default: begin
          cnt <= cnt - CYC_ONE;
          if (finish) begin
            state <= ST_IDLE;
            ready <= 1'b1;
            done <= 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // register file
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        rf[i] <= 8'h00;
      end
    end else if (take) begin
      case (op)
        OP_REG_COPY: rf[rdSel] <= rrVal;
        OP_PAIR_COPY: begin
          rf[{rdSel[4:1], 1'b0}] <= rf[{rrSel[4:1], 1'b0}];
          rf[{rdSel[4:1], 1'b1}] <= rf[{rrSel[4:1], 1'b1}];
        end
        OP_IMM_LOAD: rf[rdSel] <= imm;
        OP_IO_IN: rf[rdSel] <= ioRdata;
        OP_SHIFT: rf[rdSel] <= shRes;
        OP_TDEP: rf[rdSel][bitSel] <= status_flag_register[FLG_T];
        OP_RD_IND, OP_WR_IND, OP_CODE_RD: begin
          if (ptrMode == PM_POSTINC) begin
            {rf[ptrHi], rf[ptrLo]} <= ptrInc;
          end else if (ptrMode == PM_PREDEC && op != OP_CODE_RD) begin
            {rf[ptrHi], rf[ptrLo]} <= ptrDec;
          end
        end
        default: ;
      endcase
    end else if (finish) begin
      case (opR)
        OP_RD_IND, OP_RD_OFS, OP_RD_DIR, OP_POP: rf[rdR] <= dmemRdata;
        OP_CODE_RD: rf[rdR] <= pmemRdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // status flags; only shifts, tbit capture and flag ops touch them
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_flag_register <= STATUS_FLAG_REGISTER_RST;
    end else if (take) begin
      case (op)
        OP_SHIFT: begin
          if (shKind != SH_SWAP) begin
            status_flag_register[FLG_C] <= shC;
            status_flag_register[FLG_Z] <= shZ;
            status_flag_register[FLG_N] <= shN;
            status_flag_register[FLG_V] <= shV;
            status_flag_register[FLG_S] <= shS;
          end
        end
        OP_TCAP: status_flag_register[FLG_T] <= rrVal[bitSel];
        OP_FLAG_SET: status_flag_register[bitSel] <= 1'b1;
        OP_FLAG_CLR: status_flag_register[bitSel] <= 1'b0;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // program counter and stack pointer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= PC_RST;
    end else if (take) begin
      if (brTaken) begin
        pc <= brTgt;
      end else if (op == OP_RD_DIR || op == OP_WR_DIR) begin
        pc <= pc + 16'h0002;
      end else begin
        pc <= pc + 16'h0001;
      end
    end
  end
  // stack grows down; push writes then decrements
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sp <= SP_RST;
    end else if (take && op == OP_PUSH) begin
      sp <= sp - 16'h0001;
    end else if (take && op == OP_POP) begin
      sp <= sp + 16'h0001;
    end
  end

  // ==========================================================
  // memory and io ports
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dmemAddr <= 16'h0000;
      dmemWdata <= 8'h00;
      dmemWe <= 1'b0;
      dmemRe <= 1'b0;
      pmemAddr <= 16'h0000;
      pmemRe <= 1'b0;
      ioAddr <= 6'h00;
      ioWdata <= 8'h00;
      ioWe <= 1'b0;
    end else begin
      dmemWe <= 1'b0;
      dmemRe <= 1'b0;
      pmemRe <= 1'b0;
      ioWe <= 1'b0;
      if (take) begin
        case (op)
          OP_RD_IND: begin
            dmemRe <= 1'b1;
            dmemAddr <= indAddr;
          end
          OP_RD_OFS: begin
            dmemRe <= 1'b1;
            dmemAddr <= ofsAddr;
          end
          OP_RD_DIR: begin
            dmemRe <= 1'b1;
            dmemAddr <= dirAddr;
          end
          OP_WR_IND: begin
            dmemWe <= 1'b1;
            dmemAddr <= indAddr;
            dmemWdata <= rrVal;
          end
          OP_WR_OFS: begin
            dmemWe <= 1'b1;
            dmemAddr <= ofsAddr;
            dmemWdata <= rrVal;
          end
          OP_WR_DIR: begin
            dmemWe <= 1'b1;
            dmemAddr <= dirAddr;
            dmemWdata <= rrVal;
          end
          OP_PUSH: begin
            dmemWe <= 1'b1;
            dmemAddr <= sp;
            dmemWdata <= rrVal;
          end
          OP_POP: begin
            dmemRe <= 1'b1;
            dmemAddr <= sp + 16'h0001;
          end
          OP_CODE_RD: begin
            pmemRe <= 1'b1;
            pmemAddr <= ptrVal;
          end
          OP_IO_OUT: begin
            ioWe <= 1'b1;
            ioAddr <= opIo;
            ioWdata <= rrVal;
          end
          OP_IO_SET, OP_IO_CLR: begin
            ioAddr <= opIo;
            ioWdata <= ioRdata;
            ioWdata[bitSel] <= (op == OP_IO_SET);
          end
          default: ;
        endcase
      end else if (finish && (opR == OP_IO_SET || opR == OP_IO_CLR)) begin
        ioWe <= 1'b1;
      end
    end
  end

  // ==========================================================
  // control hand-offs and observation
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sleepReq <= 1'b0;
      wdtKick <= 1'b0;
      breakReq <= 1'b0;
      dbgData <= 8'h00;
    end else begin
      sleepReq <= take && op == OP_SLEEP;
      wdtKick <= take && op == OP_WDT;
      breakReq <= take && op == OP_BREAK;
      dbgData <= rf[dbgSel];
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_br_irq;
    take && op == OP_BR_IRQ_ON && status_flag_register[FLG_I]
      |=> pc == $past(brTgt) && !ready ##1 done && ready;
  endproperty
  a_br_irq: assert property (p_br_irq) else $error("irq branch");
  property p_br_off_skip;
    take && op == OP_BR_IRQ_OFF && status_flag_register[FLG_I]
      |=> done && pc == $past(pc) + 16'h0001;
  endproperty
  a_br_off_skip: assert property (p_br_off_skip) else $error("skip");
  property p_br_ovf;
    take && op == OP_BR_NO_OVF |=> status_flag_register == $past(status_flag_register) &&
      pc == ($past(status_flag_register[FLG_V]) ? $past(pc) + 16'h0001 : $past(brTgt));
  endproperty
  a_br_ovf: assert property (p_br_ovf) else $error("ovf branch");
  property p_rd_post;
    take && op == OP_RD_IND && ptrMode == PM_POSTINC
      |=> dmemRe && dmemAddr == $past(ptrVal) && !done ##1 done;
  endproperty
  a_rd_post: assert property (p_rd_post) else $error("post read");
  property p_rd_pre;
    take && op == OP_RD_IND && ptrMode == PM_PREDEC
      |=> dmemAddr == $past(ptrVal) - 16'h0001;
  endproperty
  a_rd_pre: assert property (p_rd_pre) else $error("pre read");
  property p_rd_ofs;
    take && op == OP_RD_OFS |=> dmemRe && dmemAddr == $past(ofsAddr);
  endproperty
  a_rd_ofs: assert property (p_rd_ofs) else $error("ofs read");
  property p_wr;
    take && op == OP_WR_IND |=> dmemWe && dmemWdata == $past(rrVal)
      ##1 done && !dmemWe;
  endproperty
  a_wr: assert property (p_wr) else $error("write");
  property p_code;
    take && op == OP_CODE_RD |=> pmemRe && pmemAddr == $past(ptrVal)
      ##1 !done ##1 done;
  endproperty
  a_code: assert property (p_code) else $error("code read");
  property p_push;
    take && op == OP_PUSH
      |=> dmemWe && dmemAddr == $past(sp) && sp == $past(sp) - 16'h0001;
  endproperty
  a_push: assert property (p_push) else $error("push");
  property p_io_bit;
    take && op == OP_IO_SET |=> !ioWe ##1 ioWe && ioWdata[$past(bitSel, 2)];
  endproperty
  a_io_bit: assert property (p_io_bit) else $error("io bit");
  property p_rot;
    take && op == OP_SHIFT && shKind == SH_ROT_UP
      |=> status_flag_register[FLG_C] == $past(rdVal[7]) && done;
  endproperty
  a_rot: assert property (p_rot) else $error("rotate");
  property p_flag;
    take && op == OP_FLAG_SET |=> status_flag_register[$past(bitSel)] &&
      ((status_flag_register ^ $past(status_flag_register)) & ~(8'h01 << $past(bitSel))) == 8'h00;
  endproperty
  a_flag: assert property (p_flag) else $error("flag set");
  property p_wdt;
    take && op == OP_WDT |=> wdtKick && done && status_flag_register == $past(status_flag_register);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog");
  c_br_taken: cover property (take && op == OP_BR_NO_OVF && brTaken);
  c_pop: cover property (take && op == OP_POP ##2 done);
  c_code_inc: cover property (take && op == OP_CODE_RD &&
    ptrMode == PM_POSTINC);
endmodule : cdm_core_exec
`default_nettype wire

// *** src/cdm_pkg.sv ***
// constants, operation codes and field positions for the execution block
// assumes one core clock; every user of these names imports cdm_pkg::*
`default_nettype none
package cdm_pkg;
  typedef enum logic [4:0] {
    OP_IDLE, OP_BR_IRQ_ON, OP_BR_IRQ_OFF, OP_BR_NO_OVF, OP_REG_COPY,
    OP_PAIR_COPY, OP_IMM_LOAD, OP_IO_IN, OP_IO_OUT, OP_RD_IND, OP_RD_OFS,
    OP_RD_DIR, OP_WR_IND, OP_WR_OFS, OP_WR_DIR, OP_CODE_RD, OP_PUSH,
    OP_POP, OP_IO_SET, OP_IO_CLR, OP_SHIFT, OP_TCAP, OP_TDEP,
    OP_FLAG_SET, OP_FLAG_CLR, OP_WDT, OP_SLEEP, OP_BREAK
  } cdm_op_e;
  typedef enum logic [2:0] {
    SH_UP, SH_DOWN, SH_ROT_UP, SH_ROT_DOWN, SH_SIGNED, SH_SWAP
  } cdm_sh_e;
  typedef enum logic [1:0] {PM_PLAIN, PM_POSTINC, PM_PREDEC} cdm_pm_e;
  // pointer pair select and low register of each pair
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [4:0] X_LO = 5'h1a;
  localparam logic [4:0] Y_LO = 5'h1c;
  localparam logic [4:0] Z_LO = 5'h1e;
  // status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;
  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  // reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h00ff;
  localparam logic [7:0] STATUS_FLAG_REGISTER_RST = 8'h00;
endpackage : cdm_pkg
`default_nettype wire

// *** src/cdm_shift_unit.sv ***
// shift, rotate and nibble-exchange unit with its flag results
// assumes the caller decides whether the flags are written back
`timescale 1ns/1ns
`default_nettype none
module cdm_shift_unit import cdm_pkg::*; #(
  parameter int W = 8
) (
  input wire cdm_sh_e kind, // shift kind
  input wire logic [W-1:0] a, // operand
  input wire logic cin, // carry in
  output logic [W-1:0] res, // result
  output logic cOut, // carry out
  output logic zOut, // zero
  output logic nOut, // negative
  output logic vOut, // overflow
  output logic sOut // sign test
);
  always_comb begin
    res = a;
    cOut = cin;
    case (kind)
      SH_UP: begin
        res = {a[W-2:0], 1'b0};
        cOut = a[W-1];
      end
      SH_DOWN: begin
        res = {1'b0, a[W-1:1]};
        cOut = a[0];
      end
      SH_ROT_UP: begin
        res = {a[W-2:0], cin};
        cOut = a[W-1];
      end
      SH_ROT_DOWN: begin
        res = {cin, a[W-1:1]};
        cOut = a[0];
      end
      SH_SIGNED: begin
        res = {a[W-1], a[W-1:1]};
        cOut = a[0];
      end
      SH_SWAP: res = {a[W/2-1:0], a[W-1:W/2]};
      default: res = a;
    endcase
  end
  assign nOut = res[W-1];
  assign zOut = (res == '0);
  assign vOut = nOut ^ cOut;
  assign sOut = nOut ^ vOut;
endmodule : cdm_shift_unit
`default_nettype wire

// *** dv/cdm_mem_model.sv ***
// data memory, code memory and io space facing the execution block
// assumes the strobe timing of cdm_core_exec on the one core clock
`timescale 1ns/1ns
`default_nettype none
module cdm_mem_model (
  input wire logic mclk, // core clock
  input wire logic [15:0] dmemAddr, // data address
  input wire logic [7:0] dmemWdata, // data write byte
  input wire logic dmemWe, // data write strobe
  input wire logic dmemRe, // data read strobe
  input wire logic [15:0] pmemAddr, // code address
  input wire logic pmemRe, // code read strobe
  input wire logic [5:0] opIo, // io address of op
  input wire logic [5:0] ioAddr, // io write address
  input wire logic [7:0] ioWdata, // io write byte
  input wire logic ioWe, // io write strobe
  output logic [7:0] dmemRdata, // data read byte
  output logic [7:0] pmemRdata, // code read byte
  output logic [7:0] ioRdata // io value at opIo
);
  logic [7:0] dmem [256];
  logic [7:0] pmem [256];
  logic [7:0] io [64];
  logic [7:0] dOld_r;
  logic [7:0] pOut_r;
  // ==========================
  // storage and answers
  // only the low address byte decodes; upper bits alias
  initial begin
    dOld_r = 8'h00;
    pOut_r = 8'h00;
  end
  // lines toggle outside a read so stale data never passes
  always @(posedge mclk) begin
    if (dmemWe) dmem[dmemAddr[7:0]] <= dmemWdata;
    if (ioWe) io[ioAddr] <= ioWdata;
    dOld_r <= dmemRdata;
    pOut_r <= pmemRe ? pmem[pmemAddr[7:0]] : ~pOut_r;
  end
  assign dmemRdata = dmemRe ? dmem[dmemAddr[7:0]] : ~dOld_r;
  assign pmemRdata = pOut_r;
  assign ioRdata = io[opIo];
endmodule : cdm_mem_model
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the execution block and its memory model
// assumes cdm_pkg, cdm_core_exec and cdm_mem_model compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top import cdm_pkg::*; ;
  logic mclk, reset_n, issue, ready, done, dmemWe, dmemRe, pmemRe, ioWe;
  logic sleepReq, wdtKick, breakReq;
  cdm_op_e op;
  cdm_pm_e ptrMode;
  cdm_sh_e shKind;
  logic [4:0] rdSel, rrSel, dbgSel;
  logic [2:0] bitSel, pulses;
  logic [1:0] ptrSel;
  logic [6:0] brOfs;
  logic [5:0] disp, opIo, ioAddr;
  logic [7:0] imm, dbgData, dmemRdata, pmemRdata, ioRdata, flags;
  logic [7:0] dmemWdata, ioWdata;
  logic [15:0] dirAddr, pc, sp, dmemAddr, pmemAddr, epc;
  int err_count, n_compared;
  cdm_core_exec uut (
    .mclk, .reset_n, .issue, .op, .rdSel, .rrSel, .bitSel, .ptrSel,
    .ptrMode, .shKind, .imm, .disp, .dirAddr, .brOfs, .opIo, .dbgSel,
    .dmemRdata, .pmemRdata, .ioRdata, .ready, .done, .pc, .status_flag_register(flags),
    .sp, .dbgData, .dmemAddr, .dmemWdata, .dmemWe, .dmemRe, .pmemAddr,
    .pmemRe, .ioAddr, .ioWdata, .ioWe, .sleepReq, .wdtKick, .breakReq
  );
  cdm_mem_model mdl (
    .mclk, .dmemAddr, .dmemWdata, .dmemWe, .dmemRe, .pmemAddr, .pmemRe,
    .opIo, .ioAddr, .ioWdata, .ioWe, .dmemRdata, .pmemRdata, .ioRdata
  );
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ==========================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // offer one op, wait for retire; checks cycles, pc step, kept flags
  task automatic run(input cdm_op_e o, input int n, input int dpc,
      input bit keep);
    int k;
    logic [7:0] f0;
    f0 = flags;
    op = o;
    issue = 1'b1;
    k = 1;
    @(negedge mclk);
    issue = 1'b0;
    while (done !== 1'b1 && k < 8) begin
      @(negedge mclk);
      k++;
    end
    if (done !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    pulses = {sleepReq, wdtKick, breakReq};
    epc = epc + 16'(dpc);
    chk(16'(k), 16'(n));
    chk(pc, epc);
    if (keep) chk(16'(flags), 16'(f0));
    // idle cycle: retire-time io writes land before the next op reads them,
    // and issue never falls and rises again within one time step
    @(negedge mclk);
  endtask : run
  task automatic put(input logic [4:0] r, input logic [7:0] v);
    rdSel = r;
    imm = v;
    run(OP_IMM_LOAD, 1, 1, 1);
  endtask : put
  task automatic creg(input logic [4:0] r, input logic [7:0] e);
    dbgSel = r;
    @(negedge mclk);
    chk(16'(dbgData), 16'(e));
  endtask : creg
  // ==========================
  // scenarios
  task automatic s_flags();
    logic [7:0] e;
    e = 8'h00;
    for (int i = 0; i < 16; i++) begin
      bitSel = 3'(i % 8);
      if (i < 8) run(OP_FLAG_SET, 1, 1, 0);
      else if (i % 2 == 0) run(OP_FLAG_CLR, 1, 1, 0);
      if (i < 8 || i % 2 == 0) e[i % 8] = (i < 8);
      chk(16'(flags), 16'(e));
    end
  endtask : s_flags
  task automatic s_branch();
    brOfs = 7'h05;
    run(OP_BR_IRQ_ON, 2, 6, 1);
    run(OP_BR_IRQ_OFF, 1, 1, 1);
    run(OP_BR_NO_OVF, 1, 1, 1);
    bitSel = 3'(FLG_V);
    run(OP_FLAG_CLR, 1, 1, 0);
    bitSel = 3'(FLG_I);
    run(OP_FLAG_CLR, 1, 1, 0);
    brOfs = 7'h7c;
    run(OP_BR_NO_OVF, 2, -3, 1);
    run(OP_BR_IRQ_OFF, 2, -3, 1);
    run(OP_BR_IRQ_ON, 1, 1, 1);
  endtask : s_branch
  task automatic s_ptr();
    logic [4:0] lo;
    logic [7:0] b, a, v, pe;
    for (int i = 0; i < 9; i++) begin
      lo = X_LO + 5'(2 * (i / 3));
      b = 8'h20 + 8'(16 * (i / 3));
      v = 8'h31 + 8'(i);
      a = (i % 3 == 2) ? b - 8'h01 : b;
      pe = (i % 3 == 1) ? b + 8'h01 : a;
      put(lo + 5'h01, 8'h00);
      put(lo, b);
      put(5'h05, v);
      ptrSel = 2'(i / 3);
      ptrMode = cdm_pm_e'(i % 3);
      rrSel = 5'h05;
      run(OP_WR_IND, 2, 1, 1);
      chk(16'(mdl.dmem[a]), 16'(v));
      creg(lo, pe);
      put(lo, b);
      rdSel = 5'h08;
      run(OP_RD_IND, 2, 1, 1);
      creg(5'h08, v);
      creg(lo, pe);
    end
  endtask : s_ptr
  task automatic s_ofs();
    for (int p = 1; p < 3; p++) begin
      put(X_LO + 5'(2 * p), 8'h40);
      put(5'h05, 8'h5a + 8'(p));
      ptrSel = 2'(p);
      disp = 6'h3f;
      run(OP_WR_OFS, 2, 1, 1);
      chk(16'(mdl.dmem[8'h7f]), 16'(8'h5a + 8'(p)));
      rdSel = 5'h09;
      run(OP_RD_OFS, 2, 1, 1);
      creg(5'h09, 8'h5a + 8'(p));
      creg(X_LO + 5'(2 * p), 8'h40);
    end
  endtask : s_ofs
  task automatic s_mem();
    put(5'h05, 8'he1);
    dirAddr = 16'h00c3;
    run(OP_WR_DIR, 2, 2, 1);
    chk(16'(mdl.dmem[8'hc3]), 16'h00e1);
    rdSel = 5'h0a;
    run(OP_RD_DIR, 2, 2, 1);
    creg(5'h0a, 8'he1);
    run(OP_PUSH, 2, 1, 1);
    chk(16'(mdl.dmem[SP_RST[7:0]]), 16'h00e1);
    chk(sp, SP_RST - 16'h0001);
    rdSel = 5'h0b;
    run(OP_POP, 2, 1, 1);
    creg(5'h0b, 8'he1);
    chk(sp, SP_RST);
    mdl.pmem[8'h12] = 8'h9d;
    put(Z_LO, 8'h12);
    for (int i = 0; i < 2; i++) begin
      rdSel = 5'(7 * i);
      ptrMode = i ? PM_POSTINC : PM_PLAIN;
      run(OP_CODE_RD, 3, 1, 1);
      creg(5'(7 * i), 8'h9d);
      creg(Z_LO, 8'h12 + 8'(i));
    end
  endtask : s_mem
  task automatic s_io();
    mdl.io[5] = 8'h50;
    opIo = 6'h05;
    bitSel = 3'h1;
    run(OP_IO_SET, 2, 1, 1);
    chk(16'(mdl.io[5]), 16'h0052);
    bitSel = 3'h4;
    run(OP_IO_CLR, 2, 1, 1);
    chk(16'(mdl.io[5]), 16'h0042);
    put(5'h05, 8'h3c);
    opIo = 6'h09;
    run(OP_IO_OUT, 1, 1, 1);
    chk(16'(mdl.io[9]), 16'h003c);
    rdSel = 5'h0c;
    run(OP_IO_IN, 1, 1, 1);
    creg(5'h0c, 8'h3c);
  endtask : s_io
  task automatic s_shift();
    cdm_sh_e kd [6] = '{SH_UP, SH_DOWN, SH_ROT_UP, SH_ROT_DOWN,
        SH_SIGNED, SH_SWAP};
    logic [7:0] di [6] = '{8'h80, 8'h81, 8'h40, 8'h02, 8'h82, 8'h3c};
    logic [7:0] dq [6] = '{8'h00, 8'h40, 8'h81, 8'h81, 8'hc1, 8'hc3};
    logic [5:0] co = 6'b100011;
    for (int i = 0; i < 6; i++) begin
      put(5'h0d, di[i]);
      bitSel = 3'(FLG_C);
      run(OP_FLAG_SET, 1, 1, 0);
      shKind = kd[i];
      run(OP_SHIFT, 1, 1, i == 5);
      creg(5'h0d, dq[i]);
      chk(16'(flags[FLG_C]), 16'(co[i]));
      if (i < 5)
        chk(16'({flags[FLG_Z], flags[FLG_N]}),
            16'({dq[i] == 8'h00, dq[i][7]}));
    end
  endtask : s_shift
  task automatic s_misc();
    put(5'h06, 8'h00);
    put(5'h05, 8'h10);
    rrSel = 5'h05;
    bitSel = 3'h4;
    run(OP_TCAP, 1, 1, 0);
    chk(16'(flags[FLG_T]), 16'h0001);
    rdSel = 5'h06;
    bitSel = 3'h0;
    run(OP_TDEP, 1, 1, 1);
    creg(5'h06, 8'h01);
    run(OP_WDT, 1, 1, 1);
    chk(16'(pulses), 16'h0002);
    run(OP_SLEEP, 1, 1, 1);
    chk(16'(pulses), 16'h0004);
    run(OP_BREAK, 1, 1, 1);
    chk(16'(pulses), 16'h0001);
    put(5'h15, 8'h5b);
    put(5'h14, 8'ha7);
    rrSel = 5'h14;
    rdSel = 5'h16;
    run(OP_REG_COPY, 1, 1, 1);
    creg(5'h16, 8'ha7);
    rdSel = 5'h18;
    run(OP_PAIR_COPY, 1, 1, 1);
    creg(5'h18, 8'ha7);
    creg(5'h19, 8'h5b);
  endtask : s_misc
  initial begin
    op = OP_IDLE;
    ptrMode = PM_PLAIN;
    shKind = SH_UP;
    {issue, rdSel, rrSel, bitSel, ptrSel, brOfs, disp, opIo} = '0;
    {imm, dirAddr, dbgSel} = '0;
    err_count = 0;
    n_compared = 0;
    epc = PC_RST;
    reset_n = 1'b0;
    repeat (20) @(negedge mclk);
    chk(pc, PC_RST);
    chk(sp, SP_RST);
    chk(16'(flags), 16'(STATUS_FLAG_REGISTER_RST));
    reset_n = 1'b1;
    s_flags();
    s_branch();
    s_ptr();
    s_ofs();
    s_mem();
    s_io();
    s_shift();
    s_misc();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
